/* File: pkg/zero_adjust_regs.svh */
// register offsets, fields, reset values, clock rate and timing durations in milliseconds
`ifndef ZERO_ADJUST_REGS_SVH
`define ZERO_ADJUST_REGS_SVH
`define CLK_HZ          10000000
`define ADDR_CTRL       8'h00
`define ADDR_STATUS     8'h04
`define ADDR_IRQ_STAT   8'h08
`define ADDR_IRQ_MASK   8'h0C
`define ADDR_OFFSET     8'h10
`define ADDR_RESIDUAL   8'h14
`define ADDR_OUTPUT     8'h18
`define ADDR_SWITCH     8'h1C
`define CTRL_ZERO_REQ   0
`define CTRL_RAMP_UP    1
`define CTRL_RAMP_DN    2
`define CTRL_STEP_UP    3
`define CTRL_STEP_DN    4
`define IRQ_DONE        0
`define IRQ_FAIL        1
`define IRQ_EXIT        2
`define IRQ_LIMIT       3
`define AUTO_RUN_MS     8000
`define HOLD_MS         5000
`define REPRESS_MS      3000
`define DEBOUNCE_MS     20
`define BLINK_MS        250
`define BLINK_FAST_MS   100
`define FLASH_MS        1000
`define OFFSET_RESET    16'h0000
`define OFFSET_LIMIT    16'h2710
`define RESID_LIMIT     16'h2710
`define NEG_LIMIT       16'hFFEC
`define RAMP_MS         10
`endif

/* File: pkg/zero_adjust_pkg.sv */
// types shared by the zero adjust sequencer
package zero_adjust_pkg;
   typedef enum logic [2:0] {
      ST_MEASURE = 3'b000,
      ST_AUTO    = 3'b001,
      ST_HOLD    = 3'b010,
      ST_RAMP    = 3'b011,
      ST_RELEASE = 3'b100
   } zero_state_e;
   typedef enum logic [1:0] {
      SW_SETPOINT = 2'b00,
      SW_ATM      = 2'b01,
      SW_STATUS   = 2'b10
   } switch_src_e;
endpackage

/* File: logic/zero_adjust_button_sequencer.sv */
// zero adjust sequencer with wishbone registers and lamp drive
//
// The Wishbone interface to the registers and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`include "zero_adjust_regs.svh"
module zero_adjust_button_sequencer #(
   parameter int AUTO_CYC = (`AUTO_RUN_MS * (`CLK_HZ / 1000)),
   parameter int HOLD_CYC = (`HOLD_MS * (`CLK_HZ / 1000)),
   parameter int REP_CYC  = (`REPRESS_MS * (`CLK_HZ / 1000)),
   parameter int DEB_CYC  = (`DEBOUNCE_MS * (`CLK_HZ / 1000)),
   parameter int BLK_CYC  = (`BLINK_MS * (`CLK_HZ / 1000)),
   parameter int FST_CYC  = (`BLINK_FAST_MS * (`CLK_HZ / 1000)),
   parameter int FLS_CYC  = (`FLASH_MS * (`CLK_HZ / 1000)),
   parameter int RMP_CYC  = (`RAMP_MS * (`CLK_HZ / 1000))
) (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [31:0] wb_dat_i,
   input  wire logic [3:0]  wb_sel_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   input  wire logic        zero_key_i,
   input  wire logic        remote_zero_i,
   input  wire logic        ctrl_zero_i,
   input  wire logic        warming_i,
   input  wire logic        atmosphere_i,
   input  wire logic [15:0] residual_i,
   input  wire logic [15:0] output_mv_i,
   input  wire logic        adj_fail_i,
   input  wire logic        setpoint_one_i,
   input  wire logic        setpoint_two_i,
   input  wire logic        atmospheric_setpoint_i,
   input  wire logic        gauge_ok_i,
   output logic             zero_start_o,
   output logic      [15:0] offset_o,
   output logic             lamp_green_o,
   output logic             contact_one_o,
   output logic             contact_two_o,
   output logic             irq_o
);
   // synchronisers and debounce state
   logic [1:0]  key_s_q, rem_s_q, ctl_s_q;
   logic        key_q, rem_q, rem_p_q, ctl_p_q;
   logic [31:0] kdb_q, rdb_q;
   // sequencer state
   zero_adjust_pkg::zero_state_e st_q, st_d;
   logic [31:0] tmr_q, rel_q, blk_q, fls_q, rmp_q;
   logic        dir_q, blink_q, fail_q, key_p_q, step_q;
   logic [15:0] off_q;
   // registers
   logic [4:0]  ctrl_q;
   logic [3:0]  ist_q, imsk_q;
   logic [3:0]  sel1_q, sel2_q;
   // two-flop sync then debounce, key and remote
   always_ff @(posedge clk_i) begin
      key_s_q <= {key_s_q[0], zero_key_i};
      rem_s_q <= {rem_s_q[0], remote_zero_i};
      ctl_s_q <= {ctl_s_q[0], ctrl_zero_i};
      ctl_p_q <= ctl_s_q[1];
   end
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         key_q   <= 1'b0;
         rem_q   <= 1'b0;
         rem_p_q <= 1'b0;
         kdb_q   <= 32'h0;
         rdb_q   <= 32'h0;
      end else begin
         rem_p_q <= rem_q;
         if (key_s_q[1] == key_q) kdb_q <= 32'h0;
         else if (kdb_q >= DEB_CYC - 1) begin
            key_q <= key_s_q[1];
            kdb_q <= 32'h0;
         end else kdb_q <= kdb_q + 32'h1;
         if (rem_s_q[1] == rem_q) rdb_q <= 32'h0;
         else if (rdb_q >= DEB_CYC - 1) begin
            rem_q <= rem_s_q[1];
            rdb_q <= 32'h0;
         end else rdb_q <= rdb_q + 32'h1;
      end
   end
   // bus decode
   wire wb_hit = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   // writes land on the edge at which the master samples ack
   wire wb_wr  = wb_cyc_i & wb_stb_i & wb_ack_o & wb_we_i & wb_sel_i[0];
   wire wr_ctl = wb_wr & (wb_adr_i == `ADDR_CTRL);
   wire wr_ist = wb_wr & (wb_adr_i == `ADDR_IRQ_STAT);
   wire wr_msk = wb_wr & (wb_adr_i == `ADDR_IRQ_MASK);
   wire wr_sw  = wb_wr & (wb_adr_i == `ADDR_SWITCH);
   wire [4:0] cmd = wr_ctl ? wb_dat_i[4:0] : 5'h0;
   // request sources and the lock
   wire locked   = warming_i | atmosphere_i;
   wire rem_rise = rem_q & ~rem_p_q;
   wire ctl_rise = ctl_s_q[1] & ~ctl_p_q;
   wire zero_req = (rem_rise | ctl_rise | cmd[`CTRL_ZERO_REQ]) & ~locked;
   wire key_rise = key_q & ~key_p_q;
   wire resid_bad = residual_i > `RESID_LIMIT;
   wire neg_out   = $signed(output_mv_i) < $signed(`NEG_LIMIT);
   wire at_limit  = dir_q ? (off_q == 16'h0) : (off_q >= `OFFSET_LIMIT);
   wire ramp_cmd  = (cmd[`CTRL_RAMP_UP] | cmd[`CTRL_RAMP_DN]) & ~locked;
   wire step_cmd  = (cmd[`CTRL_STEP_UP] | cmd[`CTRL_STEP_DN]) & ~locked;
   // no ramping while a fine step is held, so one re-press moves one unit
   wire ramp_due  = (st_q == zero_adjust_pkg::ST_RAMP) & key_q & ~step_q
                    & (rmp_q >= RMP_CYC - 1);
   wire ramp_tick = ramp_due & ~at_limit;
   wire auto_end  = (st_q == zero_adjust_pkg::ST_AUTO)
                    & (tmr_q >= AUTO_CYC - 1);
   wire auto_fail = auto_end & (resid_bad | adj_fail_i);
   wire rel_out   = (st_q == zero_adjust_pkg::ST_RELEASE)
                    & (rel_q >= HOLD_CYC - 1);
   // next-state logic
   always_comb begin
      st_d = st_q;
      unique case (st_q)
         zero_adjust_pkg::ST_MEASURE: begin
            if (key_rise & ~locked) st_d = zero_adjust_pkg::ST_HOLD;
            else if (zero_req) st_d = zero_adjust_pkg::ST_AUTO;
         end
         zero_adjust_pkg::ST_AUTO:
            if (auto_end) st_d = zero_adjust_pkg::ST_MEASURE;
         zero_adjust_pkg::ST_HOLD: begin
            if (!key_q) st_d = zero_adjust_pkg::ST_AUTO;
            else if (tmr_q >= HOLD_CYC - 1)
               st_d = zero_adjust_pkg::ST_RAMP;
         end
         zero_adjust_pkg::ST_RAMP:
            if (!key_q) st_d = zero_adjust_pkg::ST_RELEASE;
         zero_adjust_pkg::ST_RELEASE: begin
            if (rel_out) st_d = zero_adjust_pkg::ST_MEASURE;
            else if (key_rise) st_d = zero_adjust_pkg::ST_RAMP;
         end
         default: st_d = zero_adjust_pkg::ST_MEASURE;
      endcase
   end
   // sequencer registers
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_q        <= zero_adjust_pkg::ST_MEASURE;
         key_p_q     <= 1'b0;
         step_q      <= 1'b0;
         tmr_q       <= 32'h0;
         rel_q       <= 32'h0;
         rmp_q       <= 32'h0;
         fls_q       <= 32'h0;
         dir_q       <= 1'b0;
         fail_q      <= 1'b0;
         off_q       <= `OFFSET_RESET;
      end else begin
         key_p_q     <= key_q;
         st_q        <= st_d;
         tmr_q <= (st_d != st_q) ? 32'h0 : tmr_q + 32'h1;
         rmp_q <= (rmp_q >= RMP_CYC - 1) ? 32'h0 : rmp_q + 32'h1;
         if (st_q == zero_adjust_pkg::ST_RELEASE) rel_q <= rel_q + 32'h1;
         else rel_q <= 32'h0;
         if (fls_q != 32'h0) fls_q <= fls_q - 32'h1;
         // re-press within window: step or reverse
         if (st_q == zero_adjust_pkg::ST_RELEASE && key_rise) begin
            if (rel_q >= REP_CYC) begin
               dir_q <= ~dir_q;
               fls_q <= FLS_CYC;
            end else if (!at_limit) begin
               off_q <= dir_q ? off_q - 16'h1 : off_q + 16'h1;
            end
         end else if (ramp_tick) begin
            off_q <= dir_q ? off_q - 16'h1 : off_q + 16'h1;
         end else if (ramp_cmd) begin
            if (cmd[`CTRL_RAMP_UP] && off_q < `OFFSET_LIMIT)
               off_q <= off_q + 16'h1;
            else if (cmd[`CTRL_RAMP_DN] && off_q != 16'h0)
               off_q <= off_q - 16'h1;
         end else if (step_cmd) begin
            if (cmd[`CTRL_STEP_UP] && off_q < `OFFSET_LIMIT)
               off_q <= off_q + 16'h1;
            else if (cmd[`CTRL_STEP_DN] && off_q != 16'h0)
               off_q <= off_q - 16'h1;
         end
         if (st_q == zero_adjust_pkg::ST_MEASURE && st_d != st_q)
            dir_q <= 1'b0;
         if (auto_end) fail_q <= auto_fail;
         // a short re-press marks the held ramp as a fine step
         if (st_q == zero_adjust_pkg::ST_RELEASE && key_rise)
            step_q <= (rel_q < REP_CYC);
         else if (st_q != zero_adjust_pkg::ST_RAMP)
            step_q <= 1'b0;
      end
   end
   // lamp blink generator
   wire [31:0] blk_per = (fls_q != 32'h0) ? FST_CYC : BLK_CYC;
   wire blinking = (st_q != zero_adjust_pkg::ST_MEASURE) | fail_q
                   | neg_out;
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         blk_q   <= 32'h0;
         blink_q <= 1'b0;
      end else if (blk_q >= blk_per - 1) begin
         blk_q   <= 32'h0;
         blink_q <= ~blink_q;
      end else blk_q <= blk_q + 32'h1;
   end
   // interrupt status, set wins over clear
   wire [3:0] ev = {ramp_due & at_limit, rel_out, auto_fail, auto_end};
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ist_q  <= 4'h0;
         imsk_q <= 4'h0;
         ctrl_q <= 5'h0;
         sel1_q <= 4'h0;
         sel2_q <= 4'h0;
      end else begin
         ist_q <= (ist_q & ~(wr_ist ? wb_dat_i[3:0] : 4'h0)) | ev;
         if (wr_msk) imsk_q <= wb_dat_i[3:0];
         if (wr_ctl) ctrl_q <= wb_dat_i[4:0];
         if (wr_sw) begin
            sel1_q <= wb_dat_i[3:0];
            sel2_q <= wb_dat_i[7:4];
         end
      end
   end
   // switching source selection
   function automatic logic sw_pick(input logic [3:0] s, input logic sp);
      unique case (zero_adjust_pkg::switch_src_e'(s[1:0]))
         zero_adjust_pkg::SW_ATM:    sw_pick = atmospheric_setpoint_i;
         zero_adjust_pkg::SW_STATUS: sw_pick = gauge_ok_i;
         default:                    sw_pick = sp;
      endcase
   endfunction
   // read mux
   logic [31:0] rd;
   always_comb begin
      unique case (wb_adr_i)
         `ADDR_CTRL:     rd = {27'h0, ctrl_q};
         `ADDR_STATUS:   rd = {26'h0, locked, fail_q, dir_q, st_q};
         `ADDR_IRQ_STAT: rd = {28'h0, ist_q};
         `ADDR_IRQ_MASK: rd = {28'h0, imsk_q};
         `ADDR_OFFSET:   rd = {16'h0, off_q};
         `ADDR_RESIDUAL: rd = {16'h0, residual_i};
         `ADDR_OUTPUT:   rd = {16'h0, output_mv_i};
         `ADDR_SWITCH:   rd = {24'h0, sel2_q, sel1_q};
         default:        rd = 32'h0;
      endcase
   end
   // registered outputs
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o      <= 1'b0;
         wb_dat_o      <= 32'h0;
         zero_start_o  <= 1'b0;
         offset_o      <= `OFFSET_RESET;
         lamp_green_o  <= 1'b0;
         contact_one_o <= 1'b0;
         contact_two_o <= 1'b0;
         irq_o         <= 1'b0;
      end else begin
         wb_ack_o      <= wb_hit;
         wb_dat_o      <= rd;
         zero_start_o  <= (st_q != zero_adjust_pkg::ST_AUTO)
                          & (st_d == zero_adjust_pkg::ST_AUTO);
         offset_o      <= off_q;
         lamp_green_o  <= blinking ? blink_q : 1'b1;
         contact_one_o <= sw_pick(sel1_q, setpoint_one_i);
         contact_two_o <= sw_pick(sel2_q, setpoint_two_i);
         irq_o         <= |(ist_q & imsk_q);
      end
   end
   // auto run ends at the documented duration
   a_auto_length: assert property (@(posedge clk_i) disable iff (rst_i)
      auto_end |-> tmr_q == AUTO_CYC - 1)
      else $error("auto run length wrong");
   a_lock_blocks: assert property (@(posedge clk_i) disable iff (rst_i)
      (st_q == zero_adjust_pkg::ST_MEASURE && locked) |=>
      st_q == zero_adjust_pkg::ST_MEASURE)
      else $error("request taken while locked");
   a_auto_return: assert property (@(posedge clk_i) disable iff (rst_i)
      auto_end |=> st_q == zero_adjust_pkg::ST_MEASURE)
      else $error("no return after auto");
   a_release_exit: assert property (@(posedge clk_i) disable iff (rst_i)
      rel_out && !key_rise |=> st_q == zero_adjust_pkg::ST_MEASURE)
      else $error("no exit after release");
   a_fail_flag: assert property (@(posedge clk_i) disable iff (rst_i)
      auto_end && resid_bad |=> fail_q)
      else $error("residual failure missed");
   a_reverse_dir: assert property (@(posedge clk_i) disable iff (rst_i)
      st_q == zero_adjust_pkg::ST_RELEASE && key_rise && rel_q >= REP_CYC
      |=> dir_q != $past(dir_q))
      else $error("ramp not reversed");
   a_step_one: assert property (@(posedge clk_i) disable iff (rst_i)
      st_q == zero_adjust_pkg::ST_RELEASE && key_rise && rel_q < REP_CYC
      && !at_limit |=> off_q != $past(off_q))
      else $error("fine step missing");
   a_ramp_hold: assert property (@(posedge clk_i) disable iff (rst_i)
      st_q == zero_adjust_pkg::ST_HOLD && key_q && tmr_q == HOLD_CYC - 1
      |=> st_q == zero_adjust_pkg::ST_RAMP)
      else $error("ramp not entered");
endmodule

/* File: verif/operator_panel.sv */
// operator key with contact bounce and remote zero pulse source
`timescale 1ns/1ps
module operator_panel (
   input  wire logic clk_i,
   input  wire logic press_i,
   input  wire logic fire_i,
   output logic      key_o,
   output logic      remote_o
);
   logic       press_q = 1'b0;
   logic [3:0] bnc_q   = 4'h0;
   logic [3:0] pls_q   = 4'h0;
   // bounce counter on press, pulse stretcher on fire
   always_ff @(posedge clk_i) begin
      press_q <= press_i;
      if (press_i && !press_q) begin
         bnc_q <= 4'h6;
      end else if (bnc_q != 4'h0) begin
         bnc_q <= bnc_q - 4'h1;
      end
      if (fire_i) begin
         pls_q <= 4'hA;
      end else if (pls_q != 4'h0) begin
         pls_q <= pls_q - 4'h1;
      end
   end
   // key chatters for a few cycles after it is pressed
   assign key_o    = press_i & ~bnc_q[0];
   assign remote_o = (pls_q != 4'h0);
endmodule

/* File: verif/zero_adjust_button_sequencer_test.sv */
// self-checking bench for the zero adjust sequencer
`timescale 1ns/1ps
`include "zero_adjust_regs.svh"
module zero_adjust_button_sequencer_test;
   localparam int AUTO = 200;
   logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
   logic [7:0]  adr = 8'h00;
   logic [3:0]  sel = 4'hF;
   logic [31:0] dat_w = 32'h0, dat_r, q;
   logic ack, press = 1'b0, fire = 1'b0, czero = 1'b0, warm = 1'b0;
   logic atmospheric_setpoint = 1'b0, afail = 1'b0, sp1 = 1'b0, sp2 = 1'b0;
   logic asp = 1'b0, gok = 1'b0, zstart, lamp, c1, c2, irq, key, remote;
   logic [15:0] resid = 16'h0000, omv = 16'h0000, offs, o1;
   int err_total = 0, tests_run = 0, starts = 0, cycles = 0, t, s0;
   operator_panel u_panel (.clk_i(clk_i), .press_i(press), .fire_i(fire),
      .key_o(key), .remote_o(remote));
   zero_adjust_button_sequencer #(.AUTO_CYC(AUTO), .HOLD_CYC(100),
      .REP_CYC(60), .DEB_CYC(4), .BLK_CYC(8), .FST_CYC(4), .FLS_CYC(20),
      .RMP_CYC(4)) u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(dat_w),
      .wb_sel_i(sel), .wb_dat_o(dat_r), .wb_ack_o(ack),
      .zero_key_i(key), .remote_zero_i(remote), .ctrl_zero_i(czero),
      .warming_i(warm), .atmosphere_i(atmospheric_setpoint), .residual_i(resid),
      .output_mv_i(omv), .adj_fail_i(afail), .setpoint_one_i(sp1),
      .setpoint_two_i(sp2), .atmospheric_setpoint_i(asp),
      .gauge_ok_i(gok), .zero_start_o(zstart), .offset_o(offs),
      .lamp_green_o(lamp), .contact_one_o(c1), .contact_two_o(c2),
      .irq_o(irq));
   always #50 clk_i = ~clk_i;
   // run starts seen and hang guard
   always @(posedge clk_i) begin
      cycles++;
      if (zstart === 1'b1) starts++;
      if (cycles == 20000) begin
         err_total++;
         conclude();
      end
   end
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         err_total++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task tick(input int n);
      repeat (n) @(posedge clk_i);
   endtask
   // one classic wishbone cycle, waits for ack
   task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      dat_w <= d;
      // only the cycle guard ends a hang here
      do @(posedge clk_i);
      while (ack !== 1'b1);
      q = dat_r;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
   endtask
   task pulse(input int n);
      fire <= 1'b1;
      tick(1);
      fire <= 1'b0;
      tick(n);
   endtask
   task toggles(input int n);
      logic p;
      t = 0;
      p = lamp;
      repeat (n) begin
         @(posedge clk_i);
         if (lamp !== p) t++;
         p = lamp;
      end
   endtask
   task wait_irq(input int n);
      int i;
      i = 0;
      while (irq !== 1'b1 && i < n) begin
         @(posedge clk_i);
         i++;
      end
      chk({31'h0, irq}, 32'h1);
   endtask
   task note(input string s);
      $display("test %s done, mismatches %0d", s, err_total);
   endtask
   task conclude;
      $display("comparisons %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   initial begin
      tick(10);
      rst_i <= 1'b0;
      tick(5);
      bus(1'b0, `ADDR_OFFSET, 32'h0);
      chk(q, 32'h0);
      bus(1'b0, 8'h20, 32'h0);
      chk(q, 32'h0);
      toggles(30);
      chk({31'h0, lamp}, 32'h1);
      bus(1'b1, `ADDR_IRQ_MASK, 32'hF);
      note("reset");
      // requests ignored while locked
      for (int k = 0; k < 2; k++) begin
         warm <= (k == 0);
         atmospheric_setpoint <= (k == 1);
         s0 = starts;
         tick(3);
         pulse(2);
         bus(1'b1, `ADDR_CTRL, 32'h1);
         tick(60);
         chk(starts - s0, 0);
         bus(1'b0, `ADDR_STATUS, 32'h0);
         chk(q & 32'h20, 32'h20);
      end
      warm <= 1'b0;
      atmospheric_setpoint <= 1'b0;
      note("lock");
      // remote pulse runs automatic zero
      tick(3);
      s0 = starts;
      pulse(40);
      chk(starts - s0, 1);
      toggles(60);
      chk(32'(t != 0), 32'h1);
      wait_irq(AUTO + 100);
      bus(1'b0, `ADDR_IRQ_STAT, 32'h0);
      chk(q & 32'h1, 32'h1);
      bus(1'b0, `ADDR_STATUS, 32'h0);
      chk(q & 32'h7, 32'h0);
      bus(1'b1, `ADDR_IRQ_STAT, 32'hF);
      tick(2);
      chk({31'h0, irq}, 32'h0);
      note("auto");
      // controller request with residual above limit fails
      resid <= 16'h2711;
      czero <= 1'b1;
      s0 = starts;
      tick(20);
      czero <= 1'b0;
      chk(starts - s0, 1);
      wait_irq(AUTO + 100);
      bus(1'b0, `ADDR_IRQ_STAT, 32'h0);
      chk(q & 32'h2, 32'h2);
      toggles(40);
      chk(32'(t != 0), 32'h1);
      bus(1'b1, `ADDR_IRQ_MASK, 32'h0);
      tick(3);
      chk({31'h0, irq}, 32'h0);
      bus(1'b1, `ADDR_IRQ_STAT, 32'hF);
      bus(1'b1, `ADDR_IRQ_MASK, 32'hF);
      // failure flagged by the sensor side, residual right at the limit
      resid <= 16'h2710;
      afail <= 1'b1;
      s0 = starts;
      bus(1'b1, `ADDR_CTRL, 32'h1);
      wait_irq(AUTO + 100);
      chk(starts - s0, 1);
      bus(1'b0, `ADDR_IRQ_STAT, 32'h0);
      chk(q & 32'h3, 32'h3);
      bus(1'b1, `ADDR_IRQ_STAT, 32'hF);
      afail <= 1'b0;
      bus(1'b1, `ADDR_CTRL, 32'h1);
      wait_irq(AUTO + 100);
      bus(1'b0, `ADDR_IRQ_STAT, 32'h0);
      chk(q & 32'h3, 32'h1);
      bus(1'b0, `ADDR_STATUS, 32'h0);
      chk(q & 32'h10, 32'h0);
      bus(1'b1, `ADDR_IRQ_STAT, 32'hF);
      resid <= 16'h0000;
      note("fail");
      // negative output just past the limit blinks
      omv <= 16'hFFEB;
      tick(10);
      toggles(40);
      chk(32'(t != 0), 32'h1);
      omv <= 16'hFFEC;
      tick(10);
      toggles(40);
      chk(32'(t), 32'h0);
      note("negative");
      // contact sources and fieldbus steps
      sp1 <= 1'b1;
      sp2 <= 1'b0;
      gok <= 1'b1;
      bus(1'b1, `ADDR_SWITCH, 32'h0);
      tick(5);
      chk({30'h0, c1, c2}, 32'h2);
      bus(1'b1, `ADDR_SWITCH, 32'h21);
      tick(5);
      chk({30'h0, c1, c2}, 32'h1);
      asp <= 1'b1;
      sp2 <= 1'b1;
      gok <= 1'b0;
      bus(1'b1, `ADDR_SWITCH, 32'h12);
      tick(5);
      chk({30'h0, c1, c2}, 32'h1);
      bus(1'b1, `ADDR_SWITCH, 32'h0);
      tick(5);
      chk({30'h0, c1, c2}, 32'h3);
      bus(1'b1, `ADDR_CTRL, 32'h8);
      tick(3);
      chk(32'(offs), 32'h1);
      bus(1'b1, `ADDR_CTRL, 32'h10);
      tick(3);
      chk(32'(offs), 32'h0);
      bus(1'b1, `ADDR_CTRL, 32'h2);
      tick(3);
      chk(32'(offs), 32'h1);
      bus(1'b1, `ADDR_CTRL, 32'h4);
      tick(3);
      chk(32'(offs), 32'h0);
      // lane 0 disabled: the step write is dropped
      sel <= 4'hE;
      bus(1'b1, `ADDR_CTRL, 32'h8);
      tick(3);
      chk(32'(offs), 32'h0);
      sel <= 4'hF;
      note("switch");
      // held key ramps, short hold keeps offset small
      press <= 1'b1;
      toggles(40);
      chk(32'(t != 0), 32'h1);
      tick(130);
      press <= 1'b0;
      tick(10);
      o1 = offs;
      chk(32'(o1 > 16'h4 && o1 < 16'h15), 32'h1);
      tick(20);
      press <= 1'b1;
      tick(15);
      press <= 1'b0;
      tick(15);
      chk(32'(offs), 32'(o1 + 16'h1));
      tick(65);
      press <= 1'b1;
      tick(40);
      press <= 1'b0;
      tick(10);
      chk(32'(offs < o1), 32'h1);
      tick(130);
      bus(1'b0, `ADDR_IRQ_STAT, 32'h0);
      chk(q & 32'h4, 32'h4);
      bus(1'b0, `ADDR_STATUS, 32'h0);
      chk(q & 32'h7, 32'h0);
      // reset back in measure drops the offset and the interrupt
      rst_i <= 1'b1;
      tick(3);
      rst_i <= 1'b0;
      tick(2);
      chk(32'(offs), 32'h0);
      chk({31'h0, irq}, 32'h0);
      note("ramp");
      conclude();
   end
endmodule
